/* rtl/tac_ctrl.sv */
// Purpose: Serial command and conversion sequencer of a touch-screen converter.
// Assumes: Result code comes from the analog front end on the system clock.
// Notes: Serial clock logic is cleared by chip select; power state lives on clk_sys.
`timescale 1ns/100ps
`default_nettype none

module tac_ctrl import tac_pkg::*; #(
  parameter int HOLD_CYCLES = CONV_HOLD_CYCLES
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Serial link
  input wire logic serial_clock_in,
  input wire logic cs_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic conv_busy,
  output logic conv_busy_oe,
  // Analog front end
  input wire logic [CODE_W-1:0] sample_code,
  // Last command fields
  output logic [2:0] channel_select,
  output logic resolution_8bit,
  output logic reference_mode_select,
  output logic reference_power_select,
  output logic converter_power_select,
  // Power and status
  output logic adc_power_on,
  output logic ref_power_on,
  output logic panel_drive_on,
  output logic converting,
  output logic conv_overtime
);

  localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);

  logic [CMD_BITS-1:0] cmd;
  logic cmd_new;
  logic [2:0] bit_cnt;
  tac_seq_t seq_reg;
  logic [3:0] bits_left_reg;
  logic [CODE_W-1:0] sh_reg;
  logic mode8_reg;
  logic conv_reg;
  logic acq_reg;
  logic req_reg;
  logic [CODE_W-1:0] code_hs_reg;
  logic req_s1_reg;
  logic req_s2_reg;
  logic req_seen_reg;
  logic [CODE_W-1:0] code_link_reg;
  logic [XS_W-1:0] xs_in;
  logic [XS_W-1:0] xs_out;
  logic cs_n_s;
  logic new_s;
  logic busy_s;
  logic conv_s;
  logic acq_s;
  logic ack_s;
  logic new_d_reg;
  logic busy_d_reg;
  logic first_seen_reg;
  logic [HOLD_W-1:0] hold_cnt_reg;

  // Command byte receiver on the rising edge.
  tac_cmd_rx u_rx (
    .serial_clock_in(serial_clock_in),
    .cs_n(cs_n),
    .serial_data_in(serial_data_in),
    .cmd(cmd),
    .cmd_new(cmd_new),
    .bit_cnt(bit_cnt)
  );

  // Result code handshake, system side: a new word is offered only after the last is taken.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      req_reg <= 1'b0;
      code_hs_reg <= '0;
    end else if (ack_s == req_reg) begin
      req_reg <= ~req_reg;
      code_hs_reg <= sample_code;
    end
  end

  // Result code handshake, link side; the word is stable while the request is seen.
  always_ff @(posedge serial_clock_in or posedge cs_n) begin
    if (cs_n) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_seen_reg <= 1'b0;
      code_link_reg <= '0;
    end else begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      if (req_s2_reg != req_seen_reg) begin
        req_seen_reg <= req_s2_reg;
        code_link_reg <= code_hs_reg;
      end
    end
  end

  // Falling-edge sequencer: busy for one clock, then the result MSB first.
  // A completed command always wins, so the next conversion may overlap the tail.
  always_ff @(negedge serial_clock_in or posedge cs_n) begin
    if (cs_n) begin
      seq_reg <= seq_idle;
      bits_left_reg <= 4'h0;
      sh_reg <= '0;
      mode8_reg <= 1'b0;
      conv_reg <= 1'b0;
      conv_busy <= 1'b0;
      serial_data_out <= 1'b0;
    end else if (cmd_new) begin
      seq_reg <= seq_busy;
      conv_busy <= 1'b1;
      conv_reg <= 1'b1;
      serial_data_out <= 1'b0;
      mode8_reg <= cmd[CMD_RES];
      sh_reg <= code_link_reg;
    end else begin
      case (seq_reg)
        seq_busy: begin
          conv_busy <= 1'b0;
          serial_data_out <= sh_reg[CODE_W-1];
          sh_reg <= {sh_reg[CODE_W-2:0], 1'b0};
          bits_left_reg <= mode8_reg ? LAST_BIT_8 : LAST_BIT_12;
          seq_reg <= seq_shift;
        end
        seq_shift: begin
          if (bits_left_reg == 4'h0) begin
            serial_data_out <= 1'b0;
            seq_reg <= seq_idle;
          end else begin
            serial_data_out <= sh_reg[CODE_W-1];
            sh_reg <= {sh_reg[CODE_W-2:0], 1'b0};
            bits_left_reg <= bits_left_reg - 4'h1;
            if (bits_left_reg == 4'h1) begin
              conv_reg <= 1'b0;
            end
          end
        end
        default: begin
          serial_data_out <= 1'b0;
          seq_reg <= seq_idle;
        end
      endcase
    end
  end

  // Acquisition runs from the channel bits until the conversion starts.
  always_ff @(negedge serial_clock_in or posedge cs_n) begin
    if (cs_n) begin
      acq_reg <= 1'b0;
    end else begin
      acq_reg <= !cmd_new && (bit_cnt >= ACQ_START_CNT);
    end
  end

  // Every link flag the system side needs crosses here; the command byte is read directly.
  assign xs_in = {cs_n, cmd_new, conv_busy, conv_reg, acq_reg, req_seen_reg};

  tac_sync #(
    .WIDTH(XS_W),
    .INIT(XS_INIT)
  ) u_xs (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .async_in(xs_in),
    .sync_out(xs_out)
  );

  assign cs_n_s = xs_out[XS_CS];
  assign new_s = xs_out[XS_NEW];
  assign busy_s = xs_out[XS_BUSY];
  assign conv_s = xs_out[XS_CONV];
  assign acq_s = xs_out[XS_ACQ];
  assign ack_s = xs_out[XS_ACK];

  // Edge history of the crossed new-command and busy flags.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      new_d_reg <= 1'b0;
      busy_d_reg <= 1'b0;
    end else begin
      new_d_reg <= new_s;
      busy_d_reg <= busy_s;
    end
  end

  // Copy the command fields when a new command is seen; the byte is held until
  // the next command or until chip select goes high, far longer than the crossing takes.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      channel_select <= 3'h0;
      resolution_8bit <= 1'b0;
      reference_mode_select <= 1'b0;
      reference_power_select <= 1'b0;
      converter_power_select <= 1'b1;
      first_seen_reg <= 1'b0;
    end else if (new_s && !new_d_reg) begin
      channel_select <= cmd[CMD_CH_HI:CMD_CH_LO];
      resolution_8bit <= cmd[CMD_RES];
      reference_mode_select <= cmd[CMD_REFMODE];
      reference_power_select <= cmd[CMD_REF_PWR];
      converter_power_select <= cmd[CMD_ADC_PWR];
      first_seen_reg <= 1'b1;
    end
  end

  // Reference state takes effect as busy rises and ignores chip select.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ref_power_on <= 1'b0;
    end else if (busy_s && !busy_d_reg) begin
      ref_power_on <= reference_power_select;
    end
  end

  // Converter power: on until the first command, then by select bit or an active
  // conversion; a paused clock leaves the conversion flag, and so the power, alone.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      adc_power_on <= 1'b1;
    end else begin
      adc_power_on <= !first_seen_reg ||
                      (!cs_n_s && (converter_power_select || conv_s));
    end
  end

  // Panel drivers follow acquisition, and conversion too in differential mode.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      panel_drive_on <= 1'b0;
    end else begin
      panel_drive_on <= !cs_n_s && (acq_s || (conv_s && !reference_mode_select));
    end
  end

  // Output enables track chip select; the pins float once it is high.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      serial_data_oe <= 1'b0;
      conv_busy_oe <= 1'b0;
    end else begin
      serial_data_oe <= !cs_n_s;
      conv_busy_oe <= !cs_n_s;
    end
  end

  // Hold-time watch: flags a conversion that outlives the sample's hold limit.
  always_ff @(posedge clk_sys) begin
    if (!rstn || !conv_s) begin
      hold_cnt_reg <= '0;
    end else if (hold_cnt_reg != HOLD_W'(HOLD_CYCLES)) begin
      hold_cnt_reg <= hold_cnt_reg + 1'b1;
    end
  end

  // Converting status and the overtime level.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      converting <= 1'b0;
      conv_overtime <= 1'b0;
    end else begin
      converting <= conv_s;
      conv_overtime <= conv_s && (hold_cnt_reg == HOLD_W'(HOLD_CYCLES));
    end
  end

  // Checks on the system side.
  property p_cs_powerdown;
    @(posedge clk_sys) disable iff (!rstn)
      (first_seen_reg && cs_n_s) |=> !adc_power_on;
  endproperty
  a_cs_powerdown: assert property (p_cs_powerdown) else $error("converter on with cs high");

  property p_powerup_on;
    @(posedge clk_sys) disable iff (!rstn)
      !first_seen_reg |=> adc_power_on;
  endproperty
  a_powerup_on: assert property (p_powerup_on) else $error("converter off before command");

  property p_full_power;
    @(posedge clk_sys) disable iff (!rstn)
      (first_seen_reg && !cs_n_s && converter_power_select) |=> adc_power_on [*1];
  endproperty
  a_full_power: assert property (p_full_power) else $error("full power not held");

  property p_auto_down;
    @(posedge clk_sys) disable iff (!rstn)
      (first_seen_reg && !converter_power_select && !conv_s) |=> !adc_power_on;
  endproperty
  a_auto_down: assert property (p_auto_down) else $error("auto power-down missed");

  property p_single_drive;
    @(posedge clk_sys) disable iff (!rstn)
      (reference_mode_select && conv_s && !acq_s) |=> !panel_drive_on;
  endproperty
  a_single_drive: assert property (p_single_drive) else $error("panel driven in conversion");

  property p_diff_drive;
    @(posedge clk_sys) disable iff (!rstn)
      (!cs_n_s && !reference_mode_select && conv_s) |=> panel_drive_on;
  endproperty
  a_diff_drive: assert property (p_diff_drive) else $error("panel not driven");

  property p_ref_latch;
    @(posedge clk_sys) disable iff (!rstn)
      $rose(busy_s) |=> (ref_power_on == $past(reference_power_select));
  endproperty
  a_ref_latch: assert property (p_ref_latch) else $error("reference not latched");

  property p_float_on_cs;
    @(posedge clk_sys) disable iff (!rstn)
      cs_n_s |=> (!serial_data_oe && !conv_busy_oe);
  endproperty
  a_float_on_cs: assert property (p_float_on_cs) else $error("pins driven with cs high");

  // Checks on the serial clock side.
  property p_len8;
    @(negedge serial_clock_in) disable iff (cs_n)
      ($fell(conv_busy) && mode8_reg) |-> conv_reg [*7] ##1 (!conv_reg || conv_busy);
  endproperty
  a_len8: assert property (p_len8) else $error("8-bit length wrong");

  property p_len12;
    @(negedge serial_clock_in) disable iff (cs_n)
      ($fell(conv_busy) && !mode8_reg) |-> ##10 conv_reg ##1 (!conv_reg || conv_busy);
  endproperty
  a_len12: assert property (p_len12) else $error("12-bit length wrong");

  property p_busy_one;
    @(negedge serial_clock_in) disable iff (cs_n)
      $rose(conv_busy) |=> !conv_busy;
  endproperty
  a_busy_one: assert property (p_busy_one) else $error("busy longer than one clock");

  // Main scenarios.
  c_overlap: cover property (@(negedge serial_clock_in) disable iff (cs_n)
    (bit_cnt != 3'h0) && (seq_reg == seq_shift));
  c_mode8: cover property (@(negedge serial_clock_in) disable iff (cs_n)
    $fell(conv_busy) && mode8_reg);
  c_abort: cover property (@(posedge clk_sys) disable iff (!rstn)
    $fell(conv_s) && $rose(cs_n_s));
  c_overtime: cover property (@(posedge clk_sys) disable iff (!rstn)
    $rose(conv_overtime));

endmodule

`default_nettype wire

/* inc/tac_pkg.sv */
// Purpose: Shared constants and types for the touch converter serial sequencer.
// Assumes: System clock at 125 MHz; the serial clock is made by the host.
// Notes: Command byte is MSB first, start marker in bit 7.
//
// Functional notes
// - Next command may overlap the shifted result, giving a conversion every 16 clocks.
// - Converter stays powered while the serial clock pauses mid-conversion.
// - Fastest framing of 15 clocks per conversion with overlapped command is supported.
// - Results are unsigned straight binary, zero low, all ones full scale.
// - 8-bit resolution ends four clocks earlier and yields eight result bits.
// - Converter power select 1 keeps converter on; 0 selects auto power-down.
// - Single-ended reference mode drives the panel only while acquiring.
// - Differential reference mode drives the panel during acquisition and conversion.
// - After the first command, chip select high powers down at once and abandons the running conversion.
// - Reference stays on through chip select high; host turns it off by command.
// - After power-up the converter stays on until the first command is seen.
// - Data in is sampled on rising edges, data out changes on falling edges.
// - Conversion-busy changes on falling serial clock edges and is cleared at once when chip select goes high.
// - Data out is driven only while chip select is low.
// - Conversion-busy is driven only while chip select is low.
// - Serial clock edges while chip select is high are ignored.
// - Command byte: start, channel[2:0], resolution, reference mode, power select[1:0].
// - Command starts at first high data bit; every 15th or 11th clock.
// - Power select decode: 00 auto, 01 converter on, 10 reference on, 11 both.
// - Reference power state is latched when conversion-busy rises.

package tac_pkg;

  // Command byte field positions.
  localparam int CMD_BITS = 8;
  localparam int CMD_START = 7;
  localparam int CMD_CH_HI = 6;
  localparam int CMD_CH_LO = 4;
  localparam int CMD_RES = 3;
  localparam int CMD_REFMODE = 2;
  localparam int CMD_REF_PWR = 1;
  localparam int CMD_ADC_PWR = 0;

  // Result width and the count of bits that follow the first one.
  localparam int CODE_W = 12;
  localparam logic [3:0] LAST_BIT_12 = 4'hB;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;

  // Command receiver bit counts.
  localparam logic [2:0] CMD_LAST_CNT = 3'h7;
  localparam logic [2:0] ACQ_START_CNT = 3'h5;

  // Longest time a conversion may hold its sample, and its cycle count.
  localparam int CLK_SYS_PERIOD_NS = 8;
  localparam int CONV_HOLD_MAX_NS = 1600000;
  localparam int CONV_HOLD_CYCLES = CONV_HOLD_MAX_NS / CLK_SYS_PERIOD_NS;

  // Synchroniser stage count and crossing vector layout.
  localparam int SYNC_STAGES = 3;
  localparam int XS_W = 6;
  localparam int XS_CS = 5;
  localparam int XS_NEW = 4;
  localparam int XS_BUSY = 3;
  localparam int XS_CONV = 2;
  localparam int XS_ACQ = 1;
  localparam int XS_ACK = 0;
  localparam logic [5:0] XS_INIT = 6'h20;

  // Falling-edge output sequencer states.
  typedef enum logic [1:0] {seq_idle, seq_busy, seq_shift} tac_seq_t;

endpackage

/* rtl/tac_sync.sv */
// Purpose: Three-stage synchroniser with a two-stage agreement filter.
// Assumes: Inputs change no faster than a few system clocks.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none

module tac_sync import tac_pkg::*; #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // Plain shift chain; metastability settles in the first stage.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A bit moves only once the second and third stages agree, which rejects glitches.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sync_out <= INIT;
    end else begin
      sync_out <= ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & sync_out);
    end
  end

endmodule

`default_nettype wire

/* rtl/tac_cmd_rx.sv */
// Purpose: Command byte receiver on the rising serial clock edge.
// Assumes: Chip select high clears it at once, whatever the serial clock does.
// Notes: The new-command flag holds until the next rising edge.
`timescale 1ns/100ps
`default_nettype none

module tac_cmd_rx import tac_pkg::*; (
  // Link
  input wire logic serial_clock_in,
  input wire logic cs_n,
  input wire logic serial_data_in,
  // Received command
  output logic [CMD_BITS-1:0] cmd,
  output logic cmd_new,
  output logic [2:0] bit_cnt
);

  logic [CMD_BITS-2:0] sh_reg;

  // Hunt for the start marker, then gather seven more bits MSB first.
  always_ff @(posedge serial_clock_in or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= 3'h0;
      sh_reg <= '0;
      cmd <= '0;
      cmd_new <= 1'b0;
    end else begin
      cmd_new <= 1'b0;
      if (bit_cnt == 3'h0) begin
        if (serial_data_in) begin
          bit_cnt <= 3'h1;
          sh_reg <= {{(CMD_BITS-2){1'b0}}, 1'b1};
        end
      end else if (bit_cnt == CMD_LAST_CNT) begin
        cmd <= {sh_reg, serial_data_in};
        cmd_new <= 1'b1;
        bit_cnt <= 3'h0;
      end else begin
        sh_reg <= {sh_reg[CMD_BITS-3:0], serial_data_in};
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

endmodule

`default_nettype wire

/* tb/tac_host_model.sv */
// Purpose: Host serial master model that frames commands and collects shifted results.
// Assumes: Serial clock of 160 ns runs inside frames and stray bursts; data is set while it is low.
// Notes: A result is reported once its last bit is sampled; deselect drops pending ones.
`timescale 1ns/100ps
`default_nettype none

module tac_host_model (
  // Link
  output logic serial_clock_in,
  output logic cs_n,
  output logic serial_data_in,
  input wire logic sdo,
  input wire logic busy,
  // Device status sampled mid-conversion
  input wire logic [3:0] stat,
  // Collected result
  output logic res_valid,
  output logic [11:0] res_word,
  output logic [2:0] res_busy,
  output logic [3:0] res_stat
);
  int rc;
  logic hist[0:4095];
  logic bh[0:4095];
  logic [3:0] sh[0:4095];
  int sq_s[$];
  int sq_w[$];

  // The link idles deselected with the clock parked low.
  initial begin
    serial_clock_in = 1'b0;
    cs_n = 1'b1;
    serial_data_in = 1'b0;
    res_valid = 1'b0;
    res_word = '0;
    res_busy = '0;
    res_stat = '0;
    rc = 0;
  end

  // Pins are read just before the rise, so the device's own rise logic cannot race us.
  task automatic rise_edge();
    int s;
    int w;
    rc++;
    hist[rc] = sdo;
    bh[rc] = busy;
    sh[rc] = stat;
    serial_clock_in = 1'b1;
    if (sq_s.size() != 0 && rc == sq_s[0] + 8 + sq_w[0]) begin
      s = sq_s.pop_front();
      w = sq_w.pop_front();
      res_word = '0;
      for (int k = 0; k < w; k++) res_word = {res_word[10:0], hist[s + 9 + k]};
      res_busy = {bh[s + 7], bh[s + 8], bh[s + 9]};
      res_stat = sh[s + 12];
      res_valid = 1'b1;
    end
  endtask

  // One frame: command MSB first, then zeros; a gap stalls the clock before clock 12.
  task automatic frame(input logic [7:0] cmd, input int n, input int gap);
    for (int i = 1; i <= n; i++) begin
      serial_data_in = (i <= 8) ? cmd[8 - i] : 1'b0;
      if (i == 12) #(gap);
      // One period serves both resolutions, so it stays inside the faster 8-bit allowance.
      #80;
      if (i == 1 && cmd[7]) begin
        sq_s.push_back(rc + 1);
        sq_w.push_back(cmd[3] ? 8 : 12);
      end
      rise_edge();
      #80;
      serial_clock_in = 1'b0;
      res_valid = 1'b0;
    end
  endtask

  // Select with an odd offset so serial edges never meet system clock edges.
  task automatic sel();
    cs_n = 1'b0;
    serial_data_in = 1'b0;
    #203;
  endtask

  // Deselect abandons anything still in flight.
  task automatic desel();
    #80;
    cs_n = 1'b1;
    sq_s.delete();
    sq_w.delete();
  endtask

  // Deliberate clock edges with data high while deselected.
  task automatic stray(input int n);
    serial_data_in = 1'b1;
    repeat (2 * n) #80 serial_clock_in = ~serial_clock_in;
    serial_data_in = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/tb_touch_adc_serial_conversion_ctrl.sv */
// Purpose: Self-checking bench for the touch converter serial sequencer.
// Assumes: Host model frames the link; the bench drives reset and the sample code.
// Notes: Driver notes expected results in queues; a watcher compares each result.
`timescale 1ns/100ps
`default_nettype none

module tb_touch_adc_serial_conversion_ctrl import tac_pkg::*; ();
  logic clk_sys;
  logic rstn;
  logic [CODE_W-1:0] sample_code;
  wire logic serial_clock_in, cs_n, serial_data_in, sdo_w, busy_w, res_valid;
  wire logic [11:0] res_word;
  wire logic [2:0] res_busy;
  wire logic [3:0] res_stat;
  logic serial_data_out, serial_data_oe, conv_busy, conv_busy_oe;
  logic [2:0] channel_select;
  logic resolution_8bit, reference_mode_select, reference_power_select, converter_power_select;
  logic adc_power_on, ref_power_on, panel_drive_on, converting, conv_overtime;
  logic [11:0] exp_word[$];
  logic [3:0] exp_stat[$];
  logic [7:0] cmd;
  int n_fail, tests_run, cyc;

  // Released outputs float, so the host never sees a stale bit.
  assign sdo_w = serial_data_oe ? serial_data_out : 1'bz;
  assign busy_w = conv_busy_oe ? conv_busy : 1'bz;

  tac_ctrl #(.HOLD_CYCLES(400)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .serial_clock_in(serial_clock_in), .cs_n(cs_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .conv_busy(conv_busy), .conv_busy_oe(conv_busy_oe),
    .sample_code(sample_code), .channel_select(channel_select),
    .resolution_8bit(resolution_8bit), .reference_mode_select(reference_mode_select),
    .reference_power_select(reference_power_select),
    .converter_power_select(converter_power_select), .adc_power_on(adc_power_on),
    .ref_power_on(ref_power_on), .panel_drive_on(panel_drive_on), .converting(converting),
    .conv_overtime(conv_overtime));

  tac_host_model u_host (
    .serial_clock_in(serial_clock_in), .cs_n(cs_n), .serial_data_in(serial_data_in),
    .sdo(sdo_w), .busy(busy_w),
    .stat({panel_drive_on, adc_power_on, converting, conv_overtime}),
    .res_valid(res_valid), .res_word(res_word), .res_busy(res_busy), .res_stat(res_stat));

  // System clock at 125 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic cmp_link(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t link result %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_stat(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t status %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Status crosses into clk_sys through a synchroniser, so let it settle first.
  task automatic st(input logic [4:0] e);
    repeat (12) @(negedge clk_sys);
    cmp_stat({3'h0, serial_data_oe, conv_busy_oe, adc_power_on, ref_power_on, converting},
             {3'h0, e});
  endtask

  // One conversion: set the code, note what must come back, then frame the command.
  task automatic conv(input logic [7:0] c, input int n, input int gap, input logic [11:0] v);
    @(negedge clk_sys);
    sample_code = v;
    exp_word.push_back(c[3] ? {4'h0, v[11:4]} : v);
    exp_stat.push_back({~c[2], 1'b1, 1'b1, gap > 0});
    cmd = c;
    u_host.frame(c, n, gap);
  endtask

  // Watcher: each reported result is matched against the oldest note.
  always @(posedge res_valid) begin
    if (exp_word.size() == 0) begin
      cmp_link(12'h001, 12'h000);
    end else begin
      cmp_link(res_word, exp_word.pop_front());
      cmp_link({9'h0, res_busy}, 12'h002);
      cmp_link({8'h0, res_stat}, {8'h0, exp_stat.pop_front()});
    end
  end

  // A hung handshake ends the run as a mismatch.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("BAD %0t run exceeded its cycle budget", $time);
      final_report();
    end
  end

  initial begin
    rstn = 1'b0;
    sample_code = '0;
    cmd = '0;
    n_fail = 0;
    tests_run = 0;
    cyc = 0;
    void'($urandom(73));
    repeat (5) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (8) @(negedge clk_sys);
    st(5'b00100);
    cmp_stat({7'h0, converter_power_select}, 8'h01);
    u_host.sel();
    st(5'b11100);
    // Every power code, both resolutions and both reference modes, at tight framings.
    for (int i = 0; i < 8; i++) begin
      conv({1'b1, 3'($urandom), i[0], i[1], i[2:1]}, i[0] ? 11 : (i < 4 ? 16 : 15), 0,
           i == 0 ? 12'h000 : ((i == 2 || i == 3) ? 12'hFFF : 12'($urandom)));
    end
    u_host.frame(8'h00, 16, 0);
    st(5'b11110);
    cmp_stat({1'b0, channel_select, resolution_8bit, reference_mode_select,
              reference_power_select, converter_power_select}, {1'b0, cmd[6:0]});
    conv(8'hC0, 16, 0, 12'($urandom));
    u_host.frame(8'h00, 16, 0);
    st(5'b11000);
    // Long clock stall mid-conversion with the converter otherwise powered down.
    conv(8'hD2, 16, 4000, 12'($urandom));
    u_host.frame(8'h00, 16, 0);
    u_host.desel();
    st(5'b00010);
    // Abort in the middle of shifting, then stray edges while deselected.
    u_host.sel();
    u_host.frame(8'hB1, 12, 0);
    u_host.desel();
    st(5'b00000);
    u_host.stray(6);
    st(5'b00000);
    u_host.sel();
    conv(8'hF7, 15, 0, 12'($urandom));
    u_host.frame(8'h00, 16, 0);
    u_host.desel();
    st(5'b00010);
    cmp_stat(8'(exp_word.size()), 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
